//--- core/bgsc_defines.svh
// Constants of the smart battery command block: command codes, flash map, status bits.
// Assumes inclusion by bare name from core files; definitions only.
//
// Contract
// - Manufacturer name block: length plus 11 chars
// - Command 0x21 returns name from 0x1A-0x21
// - Command 0x22 returns chemistry from 0x22-0x26
// - Chemistry string never steers gauging logic
// - Command 0x23 returns twelve bytes: nine config, front-end status, pending end voltage
// - Word 0x2F: status low, pack config high
// - Status bit order, bit 3 zero
// - Front-end check fail bit shows check result
// - End-voltage-low bit set at or below threshold
// - Sealed bit follows seal state
// - Discharge-qualified bit shows valid discharge cycle
// - Safety-latched bit sticks until reset
// - Secondary over fault bit is live
// - Secondary under fault bit is live
// - Commands 0x3C-0x3F return cell millivolts
// - Flash read at reset, rewritten storing history
// - Command 0x52 returns addressed flash byte
// - Command 0x50 writes high byte at low address
`ifndef BGSC_DEFINES_SVH
`define BGSC_DEFINES_SVH

`define BGSC_CMD_MFR_NAME 8'h20
`define BGSC_CMD_DEV_NAME 8'h21
`define BGSC_CMD_CHEM 8'h22
`define BGSC_CMD_MFR_DATA 8'h23
`define BGSC_CMD_PACK_STATUS 8'h2F
`define BGSC_CMD_CELL_BASE 8'h3C
`define BGSC_CMD_FLASH_WRITE 8'h50
`define BGSC_CMD_FLASH_ADDR 8'h51
`define BGSC_CMD_FLASH_READ 8'h52

`define BGSC_DF_MFR_NAME 8'h0E
`define BGSC_DF_DEV_NAME 8'h1A
`define BGSC_DF_CHEM 8'h22
`define BGSC_DF_MFR_DATA 8'h28
`define BGSC_DF_PACK_CFG 8'h28
`define BGSC_DF_HISTORY 8'h0C

`define BGSC_MAX_MFR_NAME 4'hB
`define BGSC_MAX_DEV_NAME 4'h7
`define BGSC_MAX_CHEM 4'h4
`define BGSC_MFR_DATA_LEN 4'hC
`define BGSC_MFR_DATA_DF_LEN 4'h9

`define BGSC_ST_FE_FAIL 7
`define BGSC_ST_EDV_LOW 6
`define BGSC_ST_SEALED 5
`define BGSC_ST_DQ 4
`define BGSC_ST_ZERO 3
`define BGSC_ST_SAFETY 2
`define BGSC_ST_SOVER 1
`define BGSC_ST_SUNDER 0

`define BGSC_FLASH_DEPTH 256
`define BGSC_LOAD_CYCLES_NS 12800
`define BGSC_CLOCK_NS 50
`define BGSC_LOAD_CYCLES ((`BGSC_LOAD_CYCLES_NS + `BGSC_CLOCK_NS - 1) / `BGSC_CLOCK_NS)

`endif

//--- core/bgsc_pkg.sv
// Types shared by the smart battery command block.
// Assumes nothing beyond a SystemVerilog compiler.
package bgsc_pkg;
  typedef enum logic [1:0] {
    BGSC_KIND_NONE,
    BGSC_KIND_WORD,
    BGSC_KIND_BLOCK
  } bgsc_kind_t;

  typedef enum logic [1:0] {
    BGSC_LOAD_RUN,
    BGSC_LOAD_WAIT,
    BGSC_LOAD_IDLE
  } bgsc_load_t;
endpackage

//--- core/bgsc_flash.sv
// Configuration flash array, one read port and one write port.
// Assumes writes and reads come from the same clock; reads take one cycle.
`timescale 1ns/1ns
`default_nettype none
module bgsc_flash #(
  parameter int DEPTH = 256
) (
  input wire logic clock,
  input wire logic clockEnable,
  input wire logic writeEnable,
  input wire logic [7:0] writeAddr,
  input wire logic [7:0] writeData,
  input wire logic [7:0] readAddr,
  output logic [7:0] readData
);
  logic [7:0] cells [DEPTH];

  always_ff @(posedge clock) begin
    if (clockEnable && writeEnable) begin
      cells[writeAddr] <= writeData;
    end
  end

  always_ff @(posedge clock) begin
    if (clockEnable) begin
      readData <= cells[readAddr];
    end
  end
endmodule // bgsc_flash
`default_nettype wire

//--- core/bgsc_sync.sv
// Two-stage synchroniser for a group of level inputs from outside the clock domain.
// Assumes the inputs are quasi-static levels.
`timescale 1ns/1ns
`default_nettype none
module bgsc_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock) begin
    if (rst) begin
      stage1 <= '0;
      syncOut <= '0;
    end else if (clockEnable) begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule // bgsc_sync
`default_nettype wire

//--- core/bgsc_cmd.sv
// Smart battery command interpreter: decodes commands from the bus slave engine,
// serves words and blocks, and gives indirect access to the configuration flash.
// Assumes an SMBus protocol engine on the same clock presents decoded commands
// and pulls answer bytes one at a time; fault and measurement inputs are pins.
`timescale 1ns/1ns
`default_nettype none
`include "bgsc_defines.svh"
module bgsc_cmd #(
  parameter int FLASH_DEPTH = `BGSC_FLASH_DEPTH,
  parameter int LOAD_CYCLES = `BGSC_LOAD_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] cmdData,
  input wire logic byteReq,
  input wire logic frontEndCheckFail,
  input wire logic endVoltageLow,
  input wire logic sealed,
  input wire logic dischargeQualified,
  input wire logic safetyTrip,
  input wire logic secondaryOverFault,
  input wire logic secondaryUnderFault,
  input wire logic [7:0] frontEndStatus,
  input wire logic [15:0] pendingEndVoltage,
  input wire logic [63:0] cellVoltageReads,
  input wire logic historyStore,
  input wire logic [15:0] historyData,
  output logic cmdAccepted,
  output logic cmdRejected,
  output logic byteValid,
  output logic [7:0] byteData,
  output logic blockDone,
  output logic [7:0] packStatusFlags,
  output logic loadDone
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [7:0] syncStatus;
  bgsc_sync #(.WIDTH(8)) statusSync (
    .clock(clock),
    .rst(rst),
    .clockEnable(clockEnable),
    .asyncIn({frontEndCheckFail, endVoltageLow, sealed, dischargeQualified, 1'b0,
      safetyTrip, secondaryOverFault, secondaryUnderFault}),
    .syncOut(syncStatus)
  );

  // ---------------------------------------------------------------
  // Pack status flags
  // ---------------------------------------------------------------
  logic safetyLatch;
  always_ff @(posedge clock) begin
    if (rst) begin
      safetyLatch <= 1'b0;
    end else if (clockEnable && syncStatus[`BGSC_ST_SAFETY]) begin
      safetyLatch <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      packStatusFlags <= 8'h00;
    end else if (clockEnable) begin
      packStatusFlags[`BGSC_ST_FE_FAIL] <= syncStatus[`BGSC_ST_FE_FAIL];
      packStatusFlags[`BGSC_ST_EDV_LOW] <= syncStatus[`BGSC_ST_EDV_LOW];
      packStatusFlags[`BGSC_ST_SEALED] <= syncStatus[`BGSC_ST_SEALED];
      packStatusFlags[`BGSC_ST_DQ] <= syncStatus[`BGSC_ST_DQ];
      packStatusFlags[`BGSC_ST_ZERO] <= 1'b0;
      packStatusFlags[`BGSC_ST_SAFETY] <= safetyLatch | syncStatus[`BGSC_ST_SAFETY];
      packStatusFlags[`BGSC_ST_SOVER] <= syncStatus[`BGSC_ST_SOVER];
      packStatusFlags[`BGSC_ST_SUNDER] <= syncStatus[`BGSC_ST_SUNDER];
    end
  end

  // ---------------------------------------------------------------
  // Flash and its reset-time load
  // ---------------------------------------------------------------
  logic flashWe;
  logic [7:0] flashWa;
  logic [7:0] flashWd;
  logic [7:0] flashRa;
  logic [7:0] flashRd;
  bgsc_flash #(.DEPTH(FLASH_DEPTH)) flash (
    .clock(clock),
    .clockEnable(clockEnable),
    .writeEnable(flashWe),
    .writeAddr(flashWa),
    .writeData(flashWd),
    .readAddr(flashRa),
    .readData(flashRd)
  );

  // Pack configuration is shadowed once after reset, so the word answer needs
  // no flash cycle; a later write to its location updates the shadow too.
  bgsc_pkg::bgsc_load_t loadState;
  logic [15:0] loadCount;
  logic [7:0] packConfig;
  always_ff @(posedge clock) begin
    if (rst) begin
      loadState <= bgsc_pkg::BGSC_LOAD_RUN;
      loadCount <= 16'h0000;
      loadDone <= 1'b0;
    end else if (clockEnable) begin
      case (loadState)
        bgsc_pkg::BGSC_LOAD_RUN: begin
          if (loadCount >= 16'(LOAD_CYCLES)) begin
            loadState <= bgsc_pkg::BGSC_LOAD_WAIT;
          end else begin
            loadCount <= loadCount + 16'h0001;
          end
        end
        bgsc_pkg::BGSC_LOAD_WAIT: begin
          loadState <= bgsc_pkg::BGSC_LOAD_IDLE;
          loadDone <= 1'b1;
        end
        bgsc_pkg::BGSC_LOAD_IDLE: loadState <= bgsc_pkg::BGSC_LOAD_IDLE;
        default: loadState <= bgsc_pkg::BGSC_LOAD_RUN;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      packConfig <= 8'h00;
    end else if (clockEnable) begin
      if (loadState == bgsc_pkg::BGSC_LOAD_WAIT) begin
        packConfig <= flashRd;
      end else if (flashWe && flashWa == `BGSC_DF_PACK_CFG) begin
        packConfig <= flashWd;
      end
    end
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  bgsc_pkg::bgsc_kind_t kind;
  logic [7:0] code;
  logic [7:0] flashAddr;
  logic [3:0] index;
  logic [3:0] length;
  logic [15:0] word;
  logic histPhase;
  logic histPend;
  logic cmdOk;

  always_comb begin
    cmdOk = 1'b0;
    if (cmdWrite) begin
      cmdOk = (cmdCode == `BGSC_CMD_FLASH_WRITE) || (cmdCode == `BGSC_CMD_FLASH_ADDR);
    end else begin
      cmdOk = (cmdCode >= `BGSC_CMD_MFR_NAME && cmdCode <= `BGSC_CMD_MFR_DATA)
        || cmdCode == `BGSC_CMD_PACK_STATUS || cmdCode == `BGSC_CMD_FLASH_READ
        || (cmdCode >= `BGSC_CMD_CELL_BASE && cmdCode <= 8'h3F);
    end
  end

  // Host writes and history stores share the one write port; the host wins and
  // the history store waits a cycle.
  always_ff @(posedge clock) begin
    if (rst) begin
      flashWe <= 1'b0;
      flashWa <= 8'h00;
      flashWd <= 8'h00;
      histPhase <= 1'b0;
      histPend <= 1'b0;
    end else if (clockEnable) begin
      flashWe <= 1'b0;
      if (historyStore) begin
        histPend <= 1'b1;
      end
      if (cmdValid && cmdWrite && cmdCode == `BGSC_CMD_FLASH_WRITE && loadDone) begin
        flashWe <= 1'b1;
        flashWa <= cmdData[7:0];
        flashWd <= cmdData[15:8];
      end else if (histPend || histPhase) begin
        flashWe <= 1'b1;
        flashWa <= `BGSC_DF_HISTORY + {7'h00, histPhase};
        flashWd <= histPhase ? historyData[7:0] : historyData[15:8];
        histPhase <= ~histPhase;
        if (!histPhase && !historyStore) begin
          histPend <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flashAddr <= 8'h00;
    end else if (clockEnable && cmdValid && cmdWrite && loadDone
        && cmdCode == `BGSC_CMD_FLASH_ADDR) begin
      flashAddr <= cmdData[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cmdAccepted <= 1'b0;
      cmdRejected <= 1'b0;
    end else if (clockEnable) begin
      cmdAccepted <= cmdValid && cmdOk && loadDone;
      cmdRejected <= cmdValid && !(cmdOk && loadDone);
    end
  end

  // ---------------------------------------------------------------
  // Answer sequencing
  // ---------------------------------------------------------------
  // A read being taken must already address its first byte: the flash answers
  // one cycle late, and the first byte is used on the very next edge.
  logic [7:0] readSel;
  logic [3:0] readIdx;
  always_comb begin
    readSel = code;
    readIdx = index;
    if (cmdValid && !cmdWrite && cmdOk && loadDone) begin
      readSel = cmdCode;
      readIdx = 4'h0;
    end
    flashRa = `BGSC_DF_PACK_CFG;
    if (loadDone) begin
      case (readSel)
        `BGSC_CMD_MFR_NAME: flashRa = `BGSC_DF_MFR_NAME + {4'h0, readIdx};
        `BGSC_CMD_DEV_NAME: flashRa = `BGSC_DF_DEV_NAME + {4'h0, readIdx};
        `BGSC_CMD_CHEM: flashRa = `BGSC_DF_CHEM + {4'h0, readIdx};
        `BGSC_CMD_MFR_DATA: flashRa = `BGSC_DF_MFR_DATA + {4'h0, readIdx} - 8'h01;
        default: flashRa = flashAddr;
      endcase
    end
  end

  logic fetchWait;
  always_ff @(posedge clock) begin
    if (rst) begin
      kind <= bgsc_pkg::BGSC_KIND_NONE;
      code <= 8'h00;
      index <= 4'h0;
      length <= 4'h0;
      word <= 16'h0000;
      byteValid <= 1'b0;
      byteData <= 8'h00;
      blockDone <= 1'b0;
      fetchWait <= 1'b0;
    end else if (clockEnable) begin
      byteValid <= 1'b0;
      blockDone <= 1'b0;
      if (cmdValid && !cmdWrite && cmdOk && loadDone) begin
        code <= cmdCode;
        index <= 4'h0;
        fetchWait <= 1'b1;
        if (cmdCode >= `BGSC_CMD_MFR_NAME && cmdCode <= `BGSC_CMD_MFR_DATA) begin
          kind <= bgsc_pkg::BGSC_KIND_BLOCK;
        end else begin
          kind <= bgsc_pkg::BGSC_KIND_WORD;
        end
      end else if (fetchWait) begin
        // One cycle for the flash read of the first byte
        fetchWait <= 1'b0;
        if (kind == bgsc_pkg::BGSC_KIND_WORD) begin
          if (code == `BGSC_CMD_PACK_STATUS) begin
            word <= {packConfig, packStatusFlags};
          end else if (code == `BGSC_CMD_FLASH_READ) begin
            word <= {8'h00, flashRd};
          end else begin
            word <= cellVoltageReads[16*(code[1:0])+:16];
          end
          index <= 4'h0;
        end else begin
          case (code)
            `BGSC_CMD_MFR_NAME: length <= (flashRd[3:0] > `BGSC_MAX_MFR_NAME || flashRd[7:4] != 4'h0)
              ? `BGSC_MAX_MFR_NAME : flashRd[3:0];
            `BGSC_CMD_DEV_NAME: length <= (flashRd[3:0] > `BGSC_MAX_DEV_NAME || flashRd[7:4] != 4'h0)
              ? `BGSC_MAX_DEV_NAME : flashRd[3:0];
            `BGSC_CMD_CHEM: length <= (flashRd[3:0] > `BGSC_MAX_CHEM || flashRd[7:4] != 4'h0)
              ? `BGSC_MAX_CHEM : flashRd[3:0];
            default: length <= `BGSC_MFR_DATA_LEN;
          endcase
        end
      end else if (byteReq && kind != bgsc_pkg::BGSC_KIND_NONE) begin
        byteValid <= 1'b1;
        if (kind == bgsc_pkg::BGSC_KIND_WORD) begin
          byteData <= index[0] ? word[15:8] : word[7:0];
          if (index[0]) begin
            kind <= bgsc_pkg::BGSC_KIND_NONE;
            blockDone <= 1'b1;
          end
          index <= index + 4'h1;
        end else begin
          if (index == 4'h0) begin
            byteData <= {4'h0, length};
          end else if (code == `BGSC_CMD_MFR_DATA && index > `BGSC_MFR_DATA_DF_LEN) begin
            case (index)
              4'hA: byteData <= frontEndStatus;
              4'hB: byteData <= pendingEndVoltage[7:0];
              default: byteData <= pendingEndVoltage[15:8];
            endcase
          end else begin
            byteData <= flashRd;
          end
          if (index == length) begin
            kind <= bgsc_pkg::BGSC_KIND_NONE;
            blockDone <= 1'b1;
          end
          index <= index + 4'h1;
        end
      end
    end
  end
  // Chemistry bytes only leave on the bus; nothing else reads them.
endmodule // bgsc_cmd
`default_nettype wire

//--- test/bgsc_cmd_monitor.sv
// Checker for the smart battery command block, watching its ports only.
// Assumes it is bound into bgsc_cmd; one clock, synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module bgsc_cmd_monitor #(
  parameter int FLASH_DEPTH = 256,
  parameter int LOAD_CYCLES = 256
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic byteReq,
  input wire logic cmdAccepted,
  input wire logic cmdRejected,
  input wire logic byteValid,
  input wire logic blockDone,
  input wire logic [7:0] packStatusFlags,
  input wire logic loadDone
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  int unsigned since;
  logic taken;
  assign taken = cmdValid && clockEnable && loadDone;
  // Saturating, so it cannot wrap and fake an early load
  always_ff @(posedge clock) begin
    if (rst) since <= 0;
    else if (clockEnable && since < LOAD_CYCLES + 8) since <= since + 1;
  end
  property p_status_read;
    taken && !cmdWrite && cmdCode == 8'h2F |=> cmdAccepted && !cmdRejected;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status word read not accepted");
  property p_cell_read;
    taken && !cmdWrite && cmdCode[7:2] == 6'h0F |=> cmdAccepted;
  endproperty
  a_cell_read: assert property (p_cell_read)
    else $error("cell voltage read not accepted");
  property p_addr_write;
    taken && cmdWrite && cmdCode == 8'h51 |=> cmdAccepted;
  endproperty
  a_addr_write: assert property (p_addr_write)
    else $error("flash address write not accepted");
  property p_wrong_dir;
    taken && cmdWrite && cmdCode == 8'h52 |=> cmdRejected && !cmdAccepted;
  endproperty
  a_wrong_dir: assert property (p_wrong_dir)
    else $error("write to flash read command not refused");
  property p_early;
    cmdValid && clockEnable && !loadDone |=> cmdRejected;
  endproperty
  a_early: assert property (p_early)
    else $error("command before load not refused");
  property p_load_low;
    since < LOAD_CYCLES |-> !loadDone;
  endproperty
  a_load_low: assert property (p_load_low)
    else $error("load done too early");
  property p_load_high;
    since > LOAD_CYCLES + 3 |-> loadDone;
  endproperty
  a_load_high: assert property (p_load_high)
    else $error("load done missing");
  property p_bit3;
    packStatusFlags[3] == 1'b0;
  endproperty
  a_bit3: assert property (p_bit3)
    else $error("status bit 3 not zero");
  property p_safety;
    packStatusFlags[2] |=> packStatusFlags[2] [*3];
  endproperty
  a_safety: assert property (p_safety)
    else $error("safety bit cleared without reset");
  property p_byte_cause;
    byteValid |-> $past(byteReq);
  endproperty
  a_byte_cause: assert property (p_byte_cause)
    else $error("answer byte without request");
  property p_done_last;
    blockDone |-> byteValid;
  endproperty
  a_done_last: assert property (p_done_last)
    else $error("block end without byte");
endmodule // bgsc_cmd_monitor
bind bgsc_cmd bgsc_cmd_monitor #(.FLASH_DEPTH(FLASH_DEPTH), .LOAD_CYCLES(LOAD_CYCLES)) u_mon (
  .clock(clock), .rst(rst), .clockEnable(clockEnable), .cmdValid(cmdValid),
  .cmdWrite(cmdWrite), .cmdCode(cmdCode), .byteReq(byteReq), .cmdAccepted(cmdAccepted),
  .cmdRejected(cmdRejected), .byteValid(byteValid), .blockDone(blockDone),
  .packStatusFlags(packStatusFlags), .loadDone(loadDone));
`default_nettype wire

//--- test/bgsc_host_model.sv
// Model of the bus host engine that feeds decoded commands and pulls bytes.
// Assumes callers enter its tasks 1 ns after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module bgsc_host_model (
  input wire logic clock,
  output logic cmdValid,
  output logic cmdWrite,
  output logic [7:0] cmdCode,
  output logic [15:0] cmdData,
  output logic byteReq,
  input wire logic cmdAccepted,
  input wire logic cmdRejected,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic blockDone
);
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    cmdData = 16'h0000;
    byteReq = 1'b0;
  end
  task automatic send(input logic [7:0] c, input logic w, input logic [15:0] d,
                      output logic acc, output logic rej);
    cmdCode = c;
    cmdWrite = w;
    cmdData = d;
    cmdValid = 1'b1;
    @(posedge clock);
    #1;
    // Answer pulses stand only in the cycle after the taking edge
    acc = cmdAccepted;
    rej = cmdRejected;
    // Released fields show no stale command
    cmdValid = 1'b0;
    cmdCode = ~c;
    cmdWrite = ~w;
    cmdData = ~d;
    @(posedge clock);
    #1;
  endtask
  task automatic fetch(input int stall, output logic [7:0] b, output logic v,
                       output logic dn);
    repeat (stall) begin
      @(posedge clock);
      #1;
    end
    byteReq = 1'b1;
    @(posedge clock);
    #1;
    v = byteValid;
    b = byteData;
    dn = blockDone;
    // A gap cycle lets the flash fetch the next byte
    byteReq = 1'b0;
    @(posedge clock);
    #1;
  endtask
endmodule // bgsc_host_model
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the smart battery command block.
// Assumes bgsc_cmd, bgsc_host_model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int LOADC = 4;
  logic clock, rst, clockEnable, cmdValid, cmdWrite, byteReq, historyStore;
  logic cmdAccepted, cmdRejected, byteValid, blockDone, loadDone;
  logic acc, rej, v, dn, safeLatch;
  logic [6:0] pins;
  logic [7:0] cmdCode, byteData, packStatusFlags, frontEndStatus, b, st;
  logic [15:0] cmdData, pendingEndVoltage, historyData;
  logic [63:0] cellVoltageReads;
  logic [31:0] lfsr = 32'hE605;
  logic [7:0] fm [256];
  logic [7:0] exq [$];
  int failures, samplesChecked, cyc;
  bgsc_cmd #(.LOAD_CYCLES(LOADC)) u_bgsc_cmd (
    .clock(clock), .rst(rst), .clockEnable(clockEnable), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData), .byteReq(byteReq),
    .frontEndCheckFail(pins[6]), .endVoltageLow(pins[5]), .sealed(pins[4]),
    .dischargeQualified(pins[3]), .safetyTrip(pins[2]), .secondaryOverFault(pins[1]),
    .secondaryUnderFault(pins[0]), .frontEndStatus(frontEndStatus),
    .pendingEndVoltage(pendingEndVoltage), .cellVoltageReads(cellVoltageReads),
    .historyStore(historyStore), .historyData(historyData), .cmdAccepted(cmdAccepted),
    .cmdRejected(cmdRejected), .byteValid(byteValid), .byteData(byteData),
    .blockDone(blockDone), .packStatusFlags(packStatusFlags), .loadDone(loadDone));
  bgsc_host_model u_bgsc_host_model (
    .clock(clock), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .cmdData(cmdData), .byteReq(byteReq), .cmdAccepted(cmdAccepted),
    .cmdRejected(cmdRejected), .byteValid(byteValid), .byteData(byteData),
    .blockDone(blockDone));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h00000000);
    return lfsr;
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (failures == 0 && samplesChecked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // Transfers: queue exq holds the bytes the reference model expects
  // ----
  task automatic xfer(input logic [7:0] c, input logic w, input logic [15:0] d, input logic ok);
    int n;
    n = exq.size();
    u_bgsc_host_model.send(c, w, d, acc, rej);
    chk("cmdAccepted", acc, ok);
    chk("cmdRejected", rej, !ok);
    for (int i = 0; i < n; i++) begin
      u_bgsc_host_model.fetch(int'(rnd() & 32'h3), b, v, dn);
      chk("byteValid", v, 1'b1);
      chk("byteData", b, exq[i]);
      chk("blockDone", dn, i == n - 1);
    end
    exq.delete();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    fm[a] = d;
    xfer(8'h50, 1'b1, {d, a}, 1'b1);
  endtask
  task automatic rdf(input logic [7:0] a);
    xfer(8'h51, 1'b1, {8'h00, a}, 1'b1);
    exq = '{fm[a], 8'h00};
    xfer(8'h52, 1'b0, 16'h0000, 1'b1);
  endtask
  task automatic blk(input logic [7:0] c, input logic [7:0] base, input logic [7:0] mx);
    logic [7:0] len;
    len = fm[base] > mx ? mx : fm[base];
    exq.push_back(len);
    for (int i = 0; i < len; i++) exq.push_back(fm[8'(base + 1 + i)]);
    xfer(c, 1'b0, 16'h0000, 1'b1);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    safeLatch = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    chk("packStatusFlags", packStatusFlags, 8'h00);
    chk("loadDone", loadDone, 1'b0);
    rst = 1'b0;
    xfer(8'h2F, 1'b0, 16'h0000, 1'b0);
    for (int k = 0; k < 20 && loadDone !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    chk("loadDone", loadDone, 1'b1);
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    rst = 1'b1;
    clockEnable = 1'b1;
    pins = 7'h00;
    historyStore = 1'b0;
    historyData = 16'h0000;
    frontEndStatus = 8'h00;
    pendingEndVoltage = 16'h0000;
    cellVoltageReads = 64'h0;
    #1;
    do_reset();
    for (int a = 8'h0E; a <= 8'h30; a++) wr(8'(a), 8'(rnd()));
    wr(8'h0E, 8'h0B);
    wr(8'h1A, 8'h09);
    wr(8'h22, 8'h02);
    frontEndStatus = 8'(rnd());
    pendingEndVoltage = 16'(rnd());
    blk(8'h20, 8'h0E, 8'h0B);
    blk(8'h21, 8'h1A, 8'h07);
    blk(8'h22, 8'h22, 8'h04);
    for (int i = 0; i < 9; i++) exq.push_back(fm[8'h28 + i]);
    exq.push_front(8'h0C);
    exq.push_back(frontEndStatus);
    exq.push_back(pendingEndVoltage[7:0]);
    exq.push_back(pendingEndVoltage[15:8]);
    xfer(8'h23, 1'b0, 16'h0000, 1'b1);
    for (int k = 0; k < 4; k++) rdf(8'h0E + 8'(rnd() & 32'h1F));
    for (int k = 0; k < 8; k++) begin
      pins = (7'(rnd()) & (k == 3 ? 7'h7F : 7'h7B)) | (k == 3 ? 7'h04 : 7'h00);
      safeLatch = safeLatch | pins[2];
      repeat (5) @(posedge clock);
      #1;
      st = {pins[6:3], 1'b0, safeLatch, pins[1:0]};
      chk("packStatusFlags", packStatusFlags, st);
      exq = '{st, fm[8'h28]};
      xfer(8'h2F, 1'b0, 16'h0000, 1'b1);
    end
    cellVoltageReads = {rnd(), rnd()};
    for (int n = 0; n < 4; n++) begin
      exq = '{cellVoltageReads[16*n+:8], cellVoltageReads[16*n+8+:8]};
      xfer(8'h3C + 8'(n), 1'b0, 16'h0000, 1'b1);
    end
    xfer(8'h30, 1'b0, 16'h0000, 1'b0);
    xfer(8'h52, 1'b1, 16'h0000, 1'b0);
    xfer(8'h2F, 1'b1, 16'h0000, 1'b0);
    historyData = 16'(rnd());
    historyStore = 1'b1;
    @(posedge clock);
    #1;
    historyStore = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    fm[8'h0C] = historyData[15:8];
    fm[8'h0D] = historyData[7:0];
    rdf(8'h0C);
    rdf(8'h0D);
    pins = 7'h00;
    do_reset();
    repeat (5) @(posedge clock);
    #1;
    chk("packStatusFlags", packStatusFlags, 8'h00);
    exq = '{8'h00, fm[8'h28]};
    xfer(8'h2F, 1'b0, 16'h0000, 1'b1);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
